// ### icogt_pkg.sv
// Function
// - Offset sign 0 adds the magnitude, sign 1 subtracts it.
// - Offset magnitude is straight binary, 0 for none up to 45 mV.
// - At reset the offset register is all zeros: zero offset, positive sign.
// - Range magnitude is straight binary, 600 mV at 0 to 1000 mV at 32767.
// - At reset the range field holds mid code 16384, the 800 mV default.
// - In extended mode mid code is nominal and higher codes reach beyond.
package icogt_pkg;

  // ----------------------------------------------------------------
  // register map (index; byte address is index shifted by ADDR_LSB)
  // ----------------------------------------------------------------
  localparam int unsigned NREG      = 2;
  localparam int unsigned ADDR_LSB  = 2;
  localparam logic [29:0] IDX_OFFSET = 30'h0000_0002;
  localparam logic [29:0] IDX_SPAN   = 30'h0000_0003;
  localparam logic [0:0]  SEL_OFFSET = 1'h0;
  localparam logic [0:0]  SEL_SPAN   = 1'h1;

  localparam logic [15:0] OFFSET_RST  = 16'h0000;
  localparam logic [15:0] SPAN_RST    = 16'h4000;
  localparam logic [15:0] OFFSET_MASK = 16'h1FFF;
  localparam logic [15:0] SPAN_MASK   = 16'h7FFF;
  localparam logic [NREG-1:0][15:0] REG_RST  = {SPAN_RST, OFFSET_RST};
  localparam logic [NREG-1:0][15:0] REG_MASK = {SPAN_MASK, OFFSET_MASK};

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned OS_BIT = 12;
  localparam int unsigned OM_MSB = 11;
  localparam int unsigned FM_MSB = 14;
  localparam logic [14:0] SPAN_MID = 15'h4000;

  localparam int unsigned HTRANS_ACT_BIT = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        offset_sign;
    logic [11:0] offset_magnitude;
    logic [12:0] offset_signed;
    logic [14:0] range_magnitude;
    logic [14:0] input_span;
  } icogt_trim_t;

  typedef struct packed {
    logic       hit;
    logic [0:0] sel;
  } icogt_dec_t;

  typedef struct packed {
    logic [15:0] value;
  } icogt_reg_st_t;

endpackage

// ### icogt_trim_reg.sv
`timescale 1ns/10ps
`default_nettype none
module icogt_trim_reg
  import icogt_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] MASK    = 16'hFFFF
) (
  input  wire logic        ref_clk_i, // 20 MHz clock
  input  wire logic        rst_b_i,   // async reset, active low
  input  wire logic        we_i,      // write strobe
  input  wire logic [15:0] wdata_i,   // write data
  output logic      [15:0] q_o        // stored value
);

  icogt_reg_st_t st_q;
  icogt_reg_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (we_i) begin
      st_d.value = wdata_i & MASK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q.value <= RST_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.value;

endmodule
`default_nettype wire

// ### icogt_trim_map.sv
`timescale 1ns/10ps
`default_nettype none
module icogt_trim_map
  import icogt_pkg::*;
(
  input  wire logic [15:0] offset_reg_i, // offset register
  input  wire logic [15:0] span_reg_i,   // full-scale register
  input  wire logic        ext_mode_i,   // extended control mode
  output icogt_trim_t      trim_o        // decoded trim codes
);

  logic [12:0] mag_ext;
  logic [14:0] fm;

  always_comb begin
    mag_ext = {1'b0, offset_reg_i[OM_MSB:0]};
    fm      = span_reg_i[FM_MSB:0];
    trim_o.offset_sign      = offset_reg_i[OS_BIT];
    trim_o.offset_magnitude = offset_reg_i[OM_MSB:0];
    // sign selects direction of the same magnitude
    if (offset_reg_i[OS_BIT]) begin
      trim_o.offset_signed = 13'h0000 - mag_ext;
    end else begin
      trim_o.offset_signed = mag_ext;
    end
    trim_o.range_magnitude = fm;
    // outside extended mode the span stops at nominal
    if (ext_mode_i || fm <= SPAN_MID) begin
      trim_o.input_span = fm;
    end else begin
      trim_o.input_span = SPAN_MID;
    end
  end

endmodule
`default_nettype wire

// ### icogt_top.sv
`timescale 1ns/10ps
`default_nettype none
module icogt_top
  import icogt_pkg::*;
(
  input  wire logic        ref_clk_i,               // 20 MHz clock
  input  wire logic        rst_b_i,                 // async reset, low
  input  wire logic        hsel_i,                  // slave select
  input  wire logic [31:0] haddr_i,                 // byte address
  input  wire logic [1:0]  htrans_i,                // transfer type
  input  wire logic        hwrite_i,                // write when high
  input  wire logic [2:0]  hsize_i,                 // transfer size
  input  wire logic [31:0] hwdata_i,                // write data
  input  wire logic        hready_i,                // bus ready
  input  wire logic        extended_control_mode_i, // extended mode
  output logic      [31:0] hrdata_o,                // read data
  output logic             hreadyout_o,             // slave ready
  output logic             hresp_o,                 // always okay
  output icogt_trim_t      trim_o                   // to analog path
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ready;
    logic        resp;
    logic        seen;
    logic        wr_pend;
    logic [0:0]  wr_sel;
    logic [31:0] rdata;
    icogt_trim_t trim;
  } icogt_top_st_t;

  icogt_top_st_t           st_q;
  icogt_top_st_t           st_d;
  logic [NREG-1:0][15:0]   reg_q;
  logic [NREG-1:0]         reg_we;
  icogt_trim_t             trim_map;
  icogt_dec_t              dec;
  logic                    acc;
  logic [15:0]             rd_now;
  logic [15:0]             rd_fwd;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic icogt_dec_t decode(input logic [31:0] addr);
    icogt_dec_t r;
    r.hit = 1'b0;
    r.sel = SEL_OFFSET;
    if (addr[ADDR_LSB-1:0] == '0) begin
      if (addr[31:ADDR_LSB] == IDX_OFFSET) begin
        r.hit = 1'b1;
        r.sel = SEL_OFFSET;
      end else if (addr[31:ADDR_LSB] == IDX_SPAN) begin
        r.hit = 1'b1;
        r.sel = SEL_SPAN;
      end
    end
    return r;
  endfunction

  assign dec    = decode(haddr_i);
  assign acc    = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i;
  assign rd_now = reg_q[dec.sel];

  // a write still in its data phase is forwarded to a following read
  always_comb begin
    rd_fwd = rd_now;
    if (st_q.wr_pend && st_q.wr_sel == dec.sel) begin
      rd_fwd = hwdata_i[15:0] & REG_MASK[dec.sel];
    end
  end

  // ----------------------------------------------------------------
  // trim registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign reg_we[gi] = st_q.wr_pend && (st_q.wr_sel == 1'(gi));
      icogt_trim_reg #(
        .RST_VAL (REG_RST[gi]),
        .MASK    (REG_MASK[gi])
      ) u_reg (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .we_i      (reg_we[gi]),
        .wdata_i   (hwdata_i[15:0]),
        .q_o       (reg_q[gi])
      );
    end
  endgenerate

  icogt_trim_map u_map (
    .offset_reg_i (reg_q[SEL_OFFSET]),
    .span_reg_i   (reg_q[SEL_SPAN]),
    .ext_mode_i   (extended_control_mode_i),
    .trim_o       (trim_map)
  );

  // ----------------------------------------------------------------
  // bus slave and output registers
  // ----------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.ready   = 1'b1;
    st_d.resp    = 1'b0;
    st_d.seen    = 1'b1;
    st_d.wr_pend = 1'b0;
    st_d.trim    = trim_map;
    if (acc) begin
      st_d.wr_pend = hwrite_i && dec.hit;
      st_d.wr_sel  = dec.sel;
      if (!hwrite_i && dec.hit) begin
        st_d.rdata = {16'h0000, rd_fwd};
      end else begin
        st_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q.ready   <= 1'b1;
      st_q.resp    <= 1'b0;
      st_q.seen    <= 1'b0;
      st_q.wr_pend <= 1'b0;
      st_q.wr_sel  <= SEL_OFFSET;
      st_q.rdata   <= '0;
      st_q.trim.offset_sign      <= OFFSET_RST[OS_BIT];
      st_q.trim.offset_magnitude <= OFFSET_RST[OM_MSB:0];
      st_q.trim.offset_signed    <= '0;
      st_q.trim.range_magnitude  <= SPAN_RST[FM_MSB:0];
      st_q.trim.input_span       <= SPAN_RST[FM_MSB:0];
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata_o    = st_q.rdata;
  assign hreadyout_o = st_q.ready;
  assign hresp_o     = st_q.resp;
  assign trim_o      = st_q.trim;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic wr_off;
  logic wr_fs;
  logic rd_plain;

  assign wr_off   = st_q.wr_pend && st_q.wr_sel == SEL_OFFSET;
  assign wr_fs    = st_q.wr_pend && st_q.wr_sel == SEL_SPAN;
  assign rd_plain = acc && !hwrite_i && dec.hit && !st_q.wr_pend;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_offset_sign;
    wr_off |-> ##2 (trim_o.offset_sign == $past(hwdata_i[OS_BIT], 2));
  endproperty
  a_offset_sign: assert property (p_offset_sign)
    else $error("offset sign does not follow the written bit");

  property p_offset_dir;
    trim_o.offset_signed[OS_BIT] ==
      (trim_o.offset_sign && trim_o.offset_magnitude != '0);
  endproperty
  a_offset_dir: assert property (p_offset_dir)
    else $error("signed offset points the wrong way");

  property p_offset_mag;
    wr_off |-> ##2
      (trim_o.offset_magnitude == $past(hwdata_i[OM_MSB:0], 2));
  endproperty
  a_offset_mag: assert property (p_offset_mag)
    else $error("offset magnitude is not the written code");

  property p_offset_rst;
    !st_q.seen |-> (reg_q[SEL_OFFSET] == OFFSET_RST &&
                    trim_o.offset_signed == '0);
  endproperty
  a_offset_rst: assert property (p_offset_rst)
    else $error("offset register not cleared by reset");

  property p_range_mag;
    wr_fs |-> ##2
      (trim_o.range_magnitude == $past(hwdata_i[FM_MSB:0], 2));
  endproperty
  a_range_mag: assert property (p_range_mag)
    else $error("range magnitude is not the written code");

  property p_span_rst;
    !st_q.seen |-> (reg_q[SEL_SPAN] == SPAN_RST &&
                    trim_o.range_magnitude == SPAN_MID);
  endproperty
  a_span_rst: assert property (p_span_rst)
    else $error("range field not at mid code after reset");

  property p_ext_mode;
    extended_control_mode_i |=>
      (trim_o.input_span == $past(reg_q[SEL_SPAN][FM_MSB:0]));
  endproperty
  a_ext_mode: assert property (p_ext_mode)
    else $error("extended mode span differs from the register");

  property p_nominal_cap;
    !extended_control_mode_i |=> (trim_o.input_span <= SPAN_MID);
  endproperty
  a_nominal_cap: assert property (p_nominal_cap)
    else $error("span above nominal outside extended mode");

  property p_readback;
    rd_plain |=> (hrdata_o == {16'h0000, $past(rd_now)} && hreadyout_o);
  endproperty
  a_readback: assert property (p_readback)
    else $error("read-back does not return the stored value");

  property p_hold;
    (!st_q.wr_pend ##1 !st_q.wr_pend) |->
      $stable(reg_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("trim register changed without a write");

  property p_off_follow;
    trim_o.offset_magnitude == $past(reg_q[SEL_OFFSET][OM_MSB:0]) &&
      trim_o.offset_sign == $past(reg_q[SEL_OFFSET][OS_BIT]);
  endproperty
  a_off_follow: assert property (p_off_follow)
    else $error("offset trim does not follow its register");

  property p_span_follow;
    trim_o.range_magnitude == $past(reg_q[SEL_SPAN][FM_MSB:0]);
  endproperty
  a_span_follow: assert property (p_span_follow)
    else $error("range trim does not follow its register");

  property p_signed_pos;
    !trim_o.offset_sign |->
      (trim_o.offset_signed == {1'b0, trim_o.offset_magnitude});
  endproperty
  a_signed_pos: assert property (p_signed_pos)
    else $error("positive offset is not the plain magnitude");

  property p_signed_neg;
    trim_o.offset_sign |->
      ((trim_o.offset_signed + {1'b0, trim_o.offset_magnitude}) == 13'h0000);
  endproperty
  a_signed_neg: assert property (p_signed_neg)
    else $error("negative offset is not the negated magnitude");

  property p_off_write;
    wr_off |=> (reg_q[SEL_OFFSET] == ($past(hwdata_i[15:0]) & OFFSET_MASK));
  endproperty
  a_off_write: assert property (p_off_write)
    else $error("offset write did not land");

  property p_span_write;
    wr_fs |=> (reg_q[SEL_SPAN] == ($past(hwdata_i[15:0]) & SPAN_MASK));
  endproperty
  a_span_write: assert property (p_span_write)
    else $error("full-scale write did not land");

  property p_miss_ignored;
    acc && !dec.hit |=> !st_q.wr_pend;
  endproperty
  a_miss_ignored: assert property (p_miss_ignored)
    else $error("unmapped write reached a register");

  property p_rdata_hold;
    !acc |=> $stable(hrdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a transfer");

  property p_mid_nominal;
    trim_o.range_magnitude == SPAN_MID |->
      (trim_o.input_span == SPAN_MID);
  endproperty
  a_mid_nominal: assert property (p_mid_nominal)
    else $error("mid code does not give the nominal span");

  property p_span_le;
    trim_o.input_span <= trim_o.range_magnitude;
  endproperty
  a_span_le: assert property (p_span_le)
    else $error("span exceeds the programmed range code");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_read:   cover property (rd_plain);
  c_neg:    cover property (wr_off ##2 trim_o.offset_sign);
  c_ext_hi: cover property (extended_control_mode_i &&
                            trim_o.input_span > SPAN_MID);
  c_miss:   cover property (acc && !dec.hit);
  c_cap:    cover property (!extended_control_mode_i &&
                            trim_o.range_magnitude > SPAN_MID);

endmodule
`default_nettype wire

// ### icogt_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, \
  (got), (exp)); end end
module tb
  import icogt_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        ext_mode;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  icogt_trim_t trim;
  int          num_errors;
  int          checks;
  logic [31:0] rd;
  localparam logic [31:0] A_OFF = {IDX_OFFSET, 2'h0};
  localparam logic [31:0] A_SPN = {IDX_SPAN, 2'h0};
  logic [15:0] c_off [5] = '{16'h0000, 16'h1000, 16'h0FFF, 16'h1FFF, 16'hFFFF};
  logic [15:0] c_spn [5] = '{16'h0000, 16'h4000, 16'h4001, 16'h7FFF, 16'hFFFF};
  logic [31:0] bad_a [4] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0010,
                             32'h0000_0009};

  icogt_top DUT (
    .ref_clk_i               (ref_clk),
    .rst_b_i                 (rst_b),
    .hsel_i                  (hsel),
    .haddr_i                 (haddr),
    .htrans_i                (htrans),
    .hwrite_i                (hwrite),
    .hsize_i                 (3'h2),
    .hwdata_i                (hwdata),
    .hready_i                (hreadyout),
    .extended_control_mode_i (ext_mode),
    .hrdata_o                (hrdata),
    .hreadyout_o             (hreadyout),
    .hresp_o                 (hresp),
    .trim_o                  (trim)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic [14:0] exp_span(logic [14:0] r, logic ext);
    return (ext || r <= 15'h4000) ? r : 15'h4000;
  endfunction

  function automatic logic [12:0] exp_signed(logic [15:0] off);
    return off[12] ? 13'(-{1'b0, off[11:0]}) : {1'b0, off[11:0]};
  endfunction

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd_reg(input logic [31:0] a);
    bus(1'b0, a, $urandom, rd);
  endtask

  task automatic check_trim(input logic [15:0] off, input logic [15:0] spn,
                            input logic ext);
    `CHK(trim.offset_sign, off[12])
    `CHK(trim.offset_signed, exp_signed(off))
    `CHK(trim.offset_magnitude, off[11:0])
    `CHK(trim.range_magnitude, spn[14:0])
    `CHK(trim.input_span, exp_span(spn[14:0], ext))
  endtask

  // write both, read back, then look at the trim path
  task automatic put(input logic [31:0] off, input logic [31:0] spn,
                     input logic ext);
    wr_reg(A_OFF, off & 32'h0000_1FFF);
    wr_reg(A_SPN, spn & 32'h0000_7FFF);
    ext_mode <= ext;
    rd_reg(A_OFF);
    `CHK(rd, off & 32'h0000_1FFF)
    rd_reg(A_SPN);
    `CHK(rd, spn & 32'h0000_7FFF)
    repeat (2) @(posedge ref_clk);
    check_trim(off[15:0] & OFFSET_MASK, spn[15:0] & SPAN_MASK, ext);
  endtask

  task automatic check_defaults();
    rd_reg(A_OFF);
    `CHK(rd, 32'h0000_0000)
    rd_reg(A_SPN);
    `CHK(rd, 32'h0000_4000)
    check_trim(16'h0000, 16'h4000, ext_mode);
  endtask

  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks     = 0;
    rst_b      = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0000_0000;
    ext_mode   = 1'b0;
    void'($urandom(78203));
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    check_defaults();
    $display("test reset done");
    foreach (c_off[i]) begin
      put({16'h0000, c_off[i]}, {16'h0000, c_spn[i]}, 1'b0);
      put({16'h0000, c_off[i]}, {16'h0000, c_spn[i]}, 1'b1);
    end
    $display("test corners done");
    repeat (20) begin
      put($urandom, $urandom, 1'($urandom));
    end
    $display("test random done");
    put(32'h0000_1ABC, 32'h0000_5555, 1'b1);
    foreach (bad_a[i]) begin
      wr_reg(bad_a[i], 32'hFFFF_FFFF);
      rd_reg(bad_a[i]);
      `CHK(rd, 32'h0000_0000)
    end
    rd_reg(A_OFF);
    `CHK(rd, 32'h0000_1ABC)
    rd_reg(A_SPN);
    `CHK(rd, 32'h0000_5555)
    $display("test unmapped done");
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    check_defaults();
    $display("test second reset done");
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
